// ### hw/fault_counters.sv
`timescale 1ns/100ps
module fault_counters
  import prot_gate_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             fault_event,
  input  wire logic             new_grid_fault,
  input  wire logic             counter_reset,
  output logic [CNT_W-1:0]      fault_counter,
  output logic [CNT_W-1:0]      grid_fault_counter,
  output logic                  reset_done
);
  // Reset beats a coincident fault: software asked for a clean start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_counter <= '0;
    end else if (clk_en) begin
      if (counter_reset) begin
        fault_counter <= '0;
      end else if (fault_event) begin
        fault_counter <= fault_counter + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      grid_fault_counter <= '0;
    end else if (clk_en) begin
      if (counter_reset) begin
        grid_fault_counter <= '0;
      end else if (fault_event && new_grid_fault) begin
        grid_fault_counter <= grid_fault_counter + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_done <= 1'b0;
    end else if (clk_en) begin
      reset_done <= counter_reset;
    end
  end

  AST_FAULT_STEP: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && fault_event && !counter_reset) |=> fault_counter == $past(fault_counter) + 1'b1)
    else $error("fault counter did not step on a fault");
  AST_GRID_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && fault_event && !new_grid_fault && !counter_reset)
      |=> grid_fault_counter == $past(grid_fault_counter))
    else $error("grid counter moved on a repeated fault");
  AST_CNT_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && counter_reset) |=> (fault_counter == '0 && grid_fault_counter == '0 && reset_done))
    else $error("counter reset did not clear and indicate");
endmodule : fault_counters

// ### hw/protection_master_gate.sv
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - Enable setting, default on, silences all alarm and trip outputs
// - Global external block permit, default off
// - Either global block input blocks protection
// - Permanent trip block suppresses collective trip
// - Trip external block permit, default off
// - Permitted trip block input suppresses collective trip
// - Alarm per phase, earth, and overall
// - Trip per phase, ground, and overall
// - Status flags for availability, activity, blocks
// - Fault counter steps on every fault while active, unless a counter reset coincides
// - Grid counter holds through reclose sequence
// - Counter reset clears both, raises indication
// - Collective outputs are OR of stages
// - Active only when enabled and unblocked
module protection_master_gate
  import prot_gate_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     irq,
  input  wire logic                global_block_input_a,
  input  wire logic                global_block_input_b,
  input  wire logic                trip_ext_block_input,
  input  wire logic                ar_in_progress,
  input  wire logic [N_STAGES-1:0] stage_alarm_a,
  input  wire logic [N_STAGES-1:0] stage_alarm_b,
  input  wire logic [N_STAGES-1:0] stage_alarm_c,
  input  wire logic [N_STAGES-1:0] stage_alarm_g,
  input  wire logic [N_STAGES-1:0] stage_trip_a,
  input  wire logic [N_STAGES-1:0] stage_trip_b,
  input  wire logic [N_STAGES-1:0] stage_trip_c,
  input  wire logic [N_STAGES-1:0] stage_trip_g,
  output logic                     alarm_phase_a,
  output logic                     alarm_phase_b,
  output logic                     alarm_phase_c,
  output logic                     alarm_earth,
  output logic                     alarm_general,
  output logic                     trip_phase_a,
  output logic                     trip_phase_b,
  output logic                     trip_phase_c,
  output logic                     trip_ground,
  output logic                     trip_general,
  output logic                     prot_available,
  output logic                     prot_active,
  output logic                     global_ext_blocked_flag,
  output logic                     trip_cmd_blocked,
  output logic                     trip_ext_block,
  output logic [CNT_W-1:0]         fault_counter,
  output logic [CNT_W-1:0]         grid_fault_counter,
  output logic                     counter_reset_ind
);
  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_event;
  logic [31:0]       rdata_q;
  logic              err_q;
  logic              bus_setup;
  logic              bus_write;
  logic              addr_hit;
  logic              cnt_reset_req;
  logic              global_ext_blk_c;
  logic              trip_ext_blk_c;
  logic              active_c;
  logic              trip_blocked_c;
  logic [3:0]        alarm_raw;
  logic [3:0]        trip_raw;
  logic              alarm_any_c;
  logic              trip_any_c;
  logic              fault_trip_q;
  logic              fault_event;
  logic              trip_general_c;
  logic              alarm_general_c;

  // Bus stalls while the clock enable holds state frozen
  assign pready    = clk_en;
  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite && pready && !pslverr;
  assign pslverr   = psel && penable && err_q;
  assign prdata    = rdata_q;

  always_comb begin
    case (paddr)
      OFF_CTRL, OFF_STATUS, OFF_FAULT, OFF_GRID,
      OFF_CMD, OFF_IRQ_STAT, OFF_IRQ_MASK: addr_hit = 1'b1;
      default:                             addr_hit = 1'b0;
    endcase
  end

  // Read data captured in setup so the access phase needs no wait state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (clk_en && bus_setup) begin
      err_q   <= !addr_hit;
      rdata_q <= 32'h0000_0000;
      case (paddr)
        OFF_CTRL:     rdata_q[CTRL_W-1:0] <= ctrl_q;
        OFF_STATUS: begin
          rdata_q[STAT_AVAIL_BIT]    <= prot_available;
          rdata_q[STAT_ACTIVE_BIT]   <= prot_active;
          rdata_q[STAT_GLOB_EXT_BIT] <= global_ext_blocked_flag;
          rdata_q[STAT_TRIP_BLK_BIT] <= trip_cmd_blocked;
          rdata_q[STAT_TRIP_EXT_BIT] <= trip_ext_block;
        end
        OFF_FAULT:    rdata_q[CNT_W-1:0] <= fault_counter;
        OFF_GRID:     rdata_q[CNT_W-1:0] <= grid_fault_counter;
        OFF_IRQ_STAT: rdata_q[IRQ_W-1:0] <= irq_stat_q;
        OFF_IRQ_MASK: rdata_q[IRQ_W-1:0] <= irq_mask_q;
        default:      rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (clk_en && bus_write && paddr == OFF_CTRL) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (clk_en && bus_write && paddr == OFF_IRQ_MASK) begin
      irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  assign cnt_reset_req = bus_write && paddr == OFF_CMD && pwdata[CMD_CNT_RESET_BIT];

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= '0;
    end else if (clk_en) begin
      if (bus_write && paddr == OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat_q <= irq_stat_q | irq_event;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |((irq_stat_q | irq_event) & irq_mask_q);
    end
  end

  // Blocking and activity decisions
  assign global_ext_blk_c = ctrl_q[CTRL_GLOB_PERMIT_BIT]
                            && (global_block_input_a || global_block_input_b);
  assign active_c         = ctrl_q[CTRL_ENABLE_BIT] && !global_ext_blk_c;
  assign trip_ext_blk_c   = ctrl_q[CTRL_TRIP_PERMIT_BIT] && trip_ext_block_input;
  assign trip_blocked_c   = ctrl_q[CTRL_TRIP_BLOCK_BIT] || trip_ext_blk_c;

  // Collective signals over all stages, gated by protection activity
  assign alarm_raw = {|stage_alarm_g, |stage_alarm_c, |stage_alarm_b, |stage_alarm_a};
  assign trip_raw  = {|stage_trip_g, |stage_trip_c, |stage_trip_b, |stage_trip_a};
  assign alarm_any_c     = active_c && (|alarm_raw);
  assign trip_any_c      = active_c && (|trip_raw);
  assign alarm_general_c = alarm_any_c;
  assign trip_general_c  = trip_any_c && !trip_blocked_c;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_phase_a <= 1'b0;
      alarm_phase_b <= 1'b0;
      alarm_phase_c <= 1'b0;
      alarm_earth   <= 1'b0;
      alarm_general <= 1'b0;
    end else if (clk_en) begin
      alarm_phase_a <= active_c && alarm_raw[0];
      alarm_phase_b <= active_c && alarm_raw[1];
      alarm_phase_c <= active_c && alarm_raw[2];
      alarm_earth   <= active_c && alarm_raw[3];
      alarm_general <= alarm_general_c;
    end
  end

  // Phase trips stay as indications; only the collective command is blocked
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trip_phase_a <= 1'b0;
      trip_phase_b <= 1'b0;
      trip_phase_c <= 1'b0;
      trip_ground  <= 1'b0;
      trip_general <= 1'b0;
    end else if (clk_en) begin
      trip_phase_a <= active_c && trip_raw[0];
      trip_phase_b <= active_c && trip_raw[1];
      trip_phase_c <= active_c && trip_raw[2];
      trip_ground  <= active_c && trip_raw[3];
      trip_general <= trip_general_c;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prot_available          <= 1'b0;
      prot_active             <= 1'b0;
      global_ext_blocked_flag <= 1'b0;
      trip_cmd_blocked        <= 1'b0;
      trip_ext_block          <= 1'b0;
    end else if (clk_en) begin
      prot_available          <= ctrl_q[CTRL_ENABLE_BIT];
      prot_active             <= active_c;
      global_ext_blocked_flag <= global_ext_blk_c;
      trip_cmd_blocked        <= ctrl_q[CTRL_TRIP_BLOCK_BIT];
      trip_ext_block          <= trip_ext_blk_c;
    end
  end

  // A fault is a new stage trip decision, counted even if the command is blocked
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_trip_q <= 1'b0;
    end else if (clk_en) begin
      fault_trip_q <= trip_any_c;
    end
  end

  assign fault_event = trip_any_c && !fault_trip_q;

  assign irq_event[IRQ_ALARM_BIT]     = alarm_general_c && !alarm_general;
  assign irq_event[IRQ_TRIP_BIT]      = trip_general_c && !trip_general;
  assign irq_event[IRQ_CNT_RESET_BIT] = counter_reset_ind;

  fault_counters i_fault_counters (
    .core_clk           (core_clk),
    .rst                (rst),
    .clk_en             (clk_en),
    .fault_event        (fault_event),
    .new_grid_fault     (!ar_in_progress),
    .counter_reset      (cnt_reset_req),
    .fault_counter      (fault_counter),
    .grid_fault_counter (grid_fault_counter),
    .reset_done         (counter_reset_ind)
  );

  AST_DISABLED_SILENT: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !ctrl_q[CTRL_ENABLE_BIT]) |=> !(alarm_general || trip_general || alarm_phase_a || trip_ground))
    else $error("output produced while protection disabled");
  AST_GLOB_PERMIT_NEEDED: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !rst && !ctrl_q[CTRL_GLOB_PERMIT_BIT] && ctrl_q[CTRL_ENABLE_BIT]) |=> prot_active)
    else $error("protection blocked without permission");
  AST_GLOB_BLOCK: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && ctrl_q[CTRL_GLOB_PERMIT_BIT] && (global_block_input_a || global_block_input_b))
      |=> (!prot_active && !alarm_general && !trip_general))
    else $error("external global block not applied");
  AST_PERM_TRIP_BLOCK: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && ctrl_q[CTRL_TRIP_BLOCK_BIT]) |=> (!trip_general && trip_cmd_blocked))
    else $error("trip passed permanent block");
  AST_TRIP_PERMIT_NEEDED: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !ctrl_q[CTRL_TRIP_PERMIT_BIT]) |=> !trip_ext_block)
    else $error("trip externally blocked without permission");
  AST_EXT_TRIP_BLOCK: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && ctrl_q[CTRL_TRIP_PERMIT_BIT] && trip_ext_block_input) |=> (!trip_general && trip_ext_block))
    else $error("trip passed external block");
  AST_ALARM_COLLECT: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> alarm_general == (alarm_phase_a || alarm_phase_b || alarm_phase_c || alarm_earth))
    else $error("general alarm does not match phase alarms");
  AST_TRIP_COLLECT: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !trip_blocked_c) |=> trip_general == (trip_phase_a || trip_phase_b || trip_phase_c || trip_ground))
    else $error("general trip does not match phase trips");
  AST_STAGE_OR: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && active_c) |=> (alarm_phase_b == $past(|stage_alarm_b) && trip_phase_c == $past(|stage_trip_c)))
    else $error("collective output is not the OR of stages");
  AST_ACTIVE_STATE: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !rst) |=> prot_active == ($past(ctrl_q[CTRL_ENABLE_BIT]) && !$past(global_ext_blk_c)))
    else $error("active flag wrong");
  AST_EXT_FLAG: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> global_ext_blocked_flag == ($past(ctrl_q[CTRL_GLOB_PERMIT_BIT])
                && ($past(global_block_input_a) || $past(global_block_input_b))))
    else $error("external block flag wrong");
  AST_AVAIL_FLAG: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !rst) |=> prot_available == $past(ctrl_q[CTRL_ENABLE_BIT]))
    else $error("available flag wrong");
endmodule : protection_master_gate

// ### shared/prot_gate_pkg.sv
package prot_gate_pkg;
  localparam int N_STAGES = 4;
  localparam int CNT_W    = 16;
  localparam int ADDR_W   = 8;
  localparam int CTRL_W   = 4;
  localparam int STAT_W   = 5;
  localparam int IRQ_W    = 3;

  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FAULT    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_GRID     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CMD      = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;

  localparam int CTRL_ENABLE_BIT     = 0;
  localparam int CTRL_GLOB_PERMIT_BIT = 1;
  localparam int CTRL_TRIP_BLOCK_BIT = 2;
  localparam int CTRL_TRIP_PERMIT_BIT = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h1;

  localparam int STAT_AVAIL_BIT      = 0;
  localparam int STAT_ACTIVE_BIT     = 1;
  localparam int STAT_GLOB_EXT_BIT   = 2;
  localparam int STAT_TRIP_BLK_BIT   = 3;
  localparam int STAT_TRIP_EXT_BIT   = 4;

  localparam int IRQ_ALARM_BIT       = 0;
  localparam int IRQ_TRIP_BIT        = 1;
  localparam int IRQ_CNT_RESET_BIT   = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  localparam int CMD_CNT_RESET_BIT   = 0;
endpackage : prot_gate_pkg

// ### verif/protection_master_gate_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("wrong value at %0t got %0h exp %0h", $time, (g), (e)); end end
module protection_master_gate_tb
  import prot_gate_pkg::*;
;
  logic core_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr, irq, ar_in_progress;
  logic global_block_input_a, global_block_input_b, trip_ext_block_input, raise, drop;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [N_STAGES-1:0] stage_alarm_a, stage_alarm_b, stage_alarm_c, stage_alarm_g;
  logic [N_STAGES-1:0] stage_trip_a, stage_trip_b, stage_trip_c, stage_trip_g;
  logic alarm_phase_a, alarm_phase_b, alarm_phase_c, alarm_earth, alarm_general;
  logic trip_phase_a, trip_phase_b, trip_phase_c, trip_ground, trip_general, counter_reset_ind;
  logic prot_available, prot_active, global_ext_blocked_flag, trip_cmd_blocked, trip_ext_block;
  logic [CNT_W-1:0] fault_counter, grid_fault_counter, exp_f, exp_g;
  logic [1:0] stage_sel;
  logic [3:0] phase_sel;
  int err_total, tests_run;
  wire logic [4:0] alarm_v = {alarm_general, alarm_earth, alarm_phase_c, alarm_phase_b, alarm_phase_a};
  wire logic [4:0] trip_v = {trip_general, trip_ground, trip_phase_c, trip_phase_b, trip_phase_a};
  wire logic [4:0] stat_v = {trip_ext_block, trip_cmd_blocked, global_ext_blocked_flag, prot_active, prot_available};

  protection_master_gate i_protection_master_gate (
    .core_clk, .rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .global_block_input_a, .global_block_input_b, .trip_ext_block_input, .ar_in_progress,
    .stage_alarm_a, .stage_alarm_b, .stage_alarm_c, .stage_alarm_g,
    .stage_trip_a, .stage_trip_b, .stage_trip_c, .stage_trip_g,
    .alarm_phase_a, .alarm_phase_b, .alarm_phase_c, .alarm_earth, .alarm_general,
    .trip_phase_a, .trip_phase_b, .trip_phase_c, .trip_ground, .trip_general,
    .prot_available, .prot_active, .global_ext_blocked_flag, .trip_cmd_blocked, .trip_ext_block,
    .fault_counter, .grid_fault_counter, .counter_reset_ind);

  stage_bank_model i_stage_bank_model (
    .core_clk, .rst, .raise, .drop, .stage_sel, .phase_sel,
    .stage_alarm_a, .stage_alarm_b, .stage_alarm_c, .stage_alarm_g,
    .stage_trip_a, .stage_trip_b, .stage_trip_c, .stage_trip_g);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    #200000;
    err_total++;
    $display("watchdog expired");
    test_done();
  end

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    `CHK(pready, 1'b1)
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    `CHK(e, 1'b0)
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK(r, x)
    `CHK(e, 1'b0)
  endtask : rd_chk

  // Outputs lag the inputs by a cycle; three edges leave margin for CTRL writes too
  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask : settle

  task automatic set_in(input logic a, input logic b, input logic t);
    @(posedge core_clk);
    global_block_input_a <= a;
    global_block_input_b <= b;
    trip_ext_block_input <= t;
    settle();
  endtask : set_in

  task automatic fault(input logic [1:0] s, input logic [3:0] p, input logic inc);
    @(posedge core_clk);
    raise     <= 1'b1;
    stage_sel <= s;
    phase_sel <= p;
    @(posedge core_clk);
    raise <= 1'b0;
    repeat (5) @(posedge core_clk);
    if (inc) begin
      exp_f++;
      if (ar_in_progress !== 1'b1) begin
        exp_g++;
      end
    end
    `CHK(fault_counter, exp_f)
    `CHK(grid_fault_counter, exp_g)
  endtask : fault

  task automatic clr;
    @(posedge core_clk);
    drop <= 1'b1;
    @(posedge core_clk);
    drop <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : clr

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rd_chk(OFF_CTRL, 32'h0000_0001);
    rd_chk(OFF_STATUS, 32'h0000_0003);
    rd_chk(OFF_IRQ_MASK, 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000, r, e);
    `CHK(e, 1'b1)
    `CHK(r, 32'h0000_0000)
    wr(OFF_STATUS, 32'h0000_001F);
    rd_chk(OFF_STATUS, 32'h0000_0003);
    $display("test reset done");
  endtask : t_reset

  task automatic t_or;
    logic [3:0] p;
    for (int s = 0; s < N_STAGES; s++) begin
      for (int k = 0; k < 4; k++) begin
        p = 4'h1 << k;
        fault(2'(s), p, 1'b1);
        `CHK(alarm_v, {1'b1, p})
        `CHK(trip_v, {1'b1, p})
        clr();
        `CHK(trip_v, 5'h00)
      end
    end
    `CHK(irq, 1'b0)
    rd_chk(OFF_FAULT, {16'h0000, exp_f});
    $display("test or done");
  endtask : t_or

  task automatic t_irq;
    wr(OFF_IRQ_STAT, 32'h0000_0007);
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    fault(2'd0, 4'h1, 1'b1);
    `CHK(irq, 1'b1)
    rd_chk(OFF_IRQ_STAT, 32'h0000_0003);
    wr(OFF_IRQ_STAT, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'b0)
    rd_chk(OFF_IRQ_STAT, 32'h0000_0001);
    clr();
    wr(OFF_IRQ_MASK, 32'h0000_0000);
    $display("test irq done");
  endtask : t_irq

  task automatic t_enable;
    wr(OFF_CTRL, 32'h0000_0000);
    settle();
    `CHK(stat_v, 5'h00)
    fault(2'd1, 4'hF, 1'b0);
    `CHK(alarm_v, 5'h00)
    `CHK(trip_v, 5'h00)
    clr();
    wr(OFF_CTRL, 32'h0000_0001);
    $display("test enable done");
  endtask : t_enable

  task automatic t_glob;
    set_in(1'b1, 1'b0, 1'b0);
    fault(2'd0, 4'h1, 1'b1);
    `CHK(alarm_v, 5'h11)
    `CHK(stat_v, 5'h03)
    clr();
    wr(OFF_CTRL, 32'h0000_0003);
    settle();
    `CHK(stat_v, 5'h05)
    fault(2'd0, 4'h1, 1'b0);
    `CHK(alarm_v, 5'h00)
    clr();
    set_in(1'b0, 1'b1, 1'b0);
    `CHK(stat_v, 5'h05)
    fault(2'd3, 4'h8, 1'b0);
    `CHK(trip_v, 5'h00)
    clr();
    set_in(1'b0, 1'b0, 1'b0);
    `CHK(stat_v, 5'h03)
    wr(OFF_CTRL, 32'h0000_0001);
    $display("test global block done");
  endtask : t_glob

  task automatic t_trip;
    wr(OFF_CTRL, 32'h0000_0005);
    settle();
    `CHK(stat_v, 5'h0B)
    fault(2'd1, 4'h2, 1'b1);
    `CHK(trip_v, 5'h02)
    `CHK(alarm_v, 5'h12)
    clr();
    wr(OFF_CTRL, 32'h0000_0001);
    set_in(1'b0, 1'b0, 1'b1);
    fault(2'd2, 4'h4, 1'b1);
    `CHK(trip_v, 5'h14)
    `CHK(stat_v, 5'h03)
    clr();
    wr(OFF_CTRL, 32'h0000_0009);
    settle();
    `CHK(stat_v, 5'h13)
    fault(2'd2, 4'h4, 1'b1);
    `CHK(trip_v, 5'h04)
    clr();
    set_in(1'b0, 1'b0, 1'b0);
    `CHK(stat_v, 5'h03)
    wr(OFF_CTRL, 32'h0000_0001);
    $display("test trip block done");
  endtask : t_trip

  // Stages keep running while the gate is frozen; the fault lands on release
  task automatic t_freeze;
    @(posedge core_clk);
    clk_en <= 1'b0;
    fault(2'd0, 4'h1, 1'b0);
    `CHK(trip_v, 5'h00)
    `CHK(pready, 1'b0)
    @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (3) @(posedge core_clk);
    exp_f++;
    exp_g++;
    `CHK(trip_v, 5'h11)
    `CHK(fault_counter, exp_f)
    `CHK(grid_fault_counter, exp_g)
    clr();
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_cnt;
    int n;
    @(posedge core_clk);
    ar_in_progress <= 1'b1;
    fault(2'd0, 4'h1, 1'b1);
    clr();
    fault(2'd1, 4'h2, 1'b1);
    clr();
    @(posedge core_clk);
    ar_in_progress <= 1'b0;
    wr(OFF_IRQ_STAT, 32'h0000_0007);
    wr(OFF_IRQ_MASK, 32'h0000_0004);
    wr(OFF_CMD, 32'h0000_0001);
    n = 0;
    repeat (4) begin
      @(negedge core_clk);
      if (counter_reset_ind === 1'b1) begin
        n++;
      end
    end
    `CHK(n, 1)
    exp_f = '0;
    exp_g = '0;
    `CHK(fault_counter, exp_f)
    `CHK(grid_fault_counter, exp_g)
    `CHK(irq, 1'b1)
    rd_chk(OFF_IRQ_STAT, 32'h0000_0004);
    fault(2'd3, 4'h1, 1'b1);
    clr();
    $display("test counters done");
  endtask : t_cnt

  initial begin
    {rst, clk_en} = 2'b11;
    {psel, penable, pwrite, raise, drop, ar_in_progress} = '0;
    {global_block_input_a, global_block_input_b, trip_ext_block_input} = '0;
    paddr     = '0;
    pwdata    = '0;
    stage_sel = '0;
    phase_sel = '0;
    exp_f     = '0;
    exp_g     = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_or();
    t_irq();
    t_enable();
    t_glob();
    t_trip();
    t_freeze();
    t_cnt();
    test_done();
  end
endmodule : protection_master_gate_tb

// ### verif/stage_bank_model.sv
`timescale 1ns/100ps
module stage_bank_model
  import prot_gate_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                raise,
  input  wire logic                drop,
  input  wire logic [1:0]          stage_sel,
  input  wire logic [3:0]          phase_sel,
  output logic [N_STAGES-1:0]      stage_alarm_a,
  output logic [N_STAGES-1:0]      stage_alarm_b,
  output logic [N_STAGES-1:0]      stage_alarm_c,
  output logic [N_STAGES-1:0]      stage_alarm_g,
  output logic [N_STAGES-1:0]      stage_trip_a,
  output logic [N_STAGES-1:0]      stage_trip_b,
  output logic [N_STAGES-1:0]      stage_trip_c,
  output logic [N_STAGES-1:0]      stage_trip_g
);
  logic [3:0][N_STAGES-1:0] alarm_q;
  logic [3:0][N_STAGES-1:0] trip_q;
  logic                     pend_q;

  // A stage picks up first and trips one cycle later, as real stages do
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_q <= '0;
      trip_q  <= '0;
      pend_q  <= 1'b0;
    end else if (drop) begin
      alarm_q <= '0;
      trip_q  <= '0;
      pend_q  <= 1'b0;
    end else if (raise) begin
      for (int k = 0; k < 4; k++) begin
        if (phase_sel[k]) begin
          alarm_q[k][stage_sel] <= 1'b1;
        end
      end
      pend_q <= 1'b1;
    end else if (pend_q) begin
      trip_q <= alarm_q;
      pend_q <= 1'b0;
    end
  end

  assign stage_alarm_a = alarm_q[0];
  assign stage_alarm_b = alarm_q[1];
  assign stage_alarm_c = alarm_q[2];
  assign stage_alarm_g = alarm_q[3];
  assign stage_trip_a  = trip_q[0];
  assign stage_trip_b  = trip_q[1];
  assign stage_trip_c  = trip_q[2];
  assign stage_trip_g  = trip_q[3];
endmodule : stage_bank_model
